/* File: inc/iomap_pkg.sv */
/*
  Constants for the I/O space remap decoder: configuration register
  location and layout, unlock sequence values, and peripheral windows.
  Assumes a 16-bit I/O byte address from the processor core.
*/
package iomap_pkg;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  localparam int IO_ADDR_W = 16;
  localparam logic [15:0] CFG_ADDR = 16'h0022;
  localparam logic [15:0] CFG_ADDR_HI = 16'h0023;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int ESE_BIT = 15;
  localparam int TIMER_REMAP_BIT = 0;
  localparam int DMA_REMAP_BIT = 2;
  localparam int MINTC_REMAP_BIT = 3;
  localparam int SINTC_REMAP_BIT = 4;
  localparam int SERIAL0_REMAP_BIT = 5;
  localparam int SERIAL1_REMAP_BIT = 6;
  localparam logic [15:0] REMAP_MASK = 16'h007D;

  // ****************************************************************
  // Unlock sequence values
  // ****************************************************************
  localparam logic [7:0] UNLOCK_B1 = 8'h00;
  localparam logic [7:0] UNLOCK_B2 = 8'h80;
  localparam logic [15:0] UNLOCK_W3 = 16'h0080;

  // ****************************************************************
  // Address spaces and peripheral windows
  // ****************************************************************
  localparam logic [3:0] EXP_SLOT = 4'hF;
  localparam int NPER = 6;
  localparam int NWIN = 7;
  localparam int PER_TIMER = 0;
  localparam int PER_DMA = 1;
  localparam int PER_MINTC = 2;
  localparam int PER_SINTC = 3;
  localparam int PER_SERIAL0 = 4;
  localparam int PER_SERIAL1 = 5;
  // Window 6 is the DMA page block, owned by the DMA unit
  localparam logic [15:0] EXP_LO [0:NWIN-1] = '{16'hF040, 16'hF000,
    16'hF020, 16'hF0A0, 16'hF4F8, 16'hF8F8, 16'hF080};
  localparam logic [15:0] EXP_HI [0:NWIN-1] = '{16'hF05F, 16'hF01F,
    16'hF03F, 16'hF0BF, 16'hF4FF, 16'hF8FF, 16'hF09F};
  localparam logic [15:0] LEG_LO [0:NWIN-1] = '{16'h0040, 16'h0000,
    16'h0020, 16'h00A0, 16'h03F8, 16'h02F8, 16'h0080};
  localparam logic [15:0] LEG_HI [0:NWIN-1] = '{16'h005F, 16'h001F,
    16'h003F, 16'h00BF, 16'h03FF, 16'h02FF, 16'h009F};
  localparam int WIN_REMAP_BIT [0:NWIN-1] = '{TIMER_REMAP_BIT,
    DMA_REMAP_BIT, MINTC_REMAP_BIT, SINTC_REMAP_BIT,
    SERIAL0_REMAP_BIT, SERIAL1_REMAP_BIT, DMA_REMAP_BIT};
  localparam logic [6:0] PER_WIN [0:NPER-1] = '{7'h01, 7'h42, 7'h04,
    7'h08, 7'h10, 7'h20};

endpackage : iomap_pkg

/* File: hdl/unlock_seq.sv */
/*
  Unlock sequence watcher: follows the three-write pattern that opens
  the expanded I/O space and pulses once when it completes.
  Assumes one-cycle request strobes from the core on the same clock.
*/
`timescale 1ns/1ns
module unlock_seq
  import iomap_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Core I/O cycle
  input wire logic io_req_in,
  input wire logic io_wr_in,
  input wire logic io_word_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [15:0] io_wdata_in,
  // Sequence complete
  output logic unlock_out
);

  typedef enum logic [1:0] {IDLE, GOT_FIRST, GOT_SECOND} seq_t;

  seq_t state_r, state_nxt;
  logic unlock_r, unlock_nxt;

  // ****************************************************************
  // Step decode
  // ****************************************************************
  wire logic wr = io_req_in & io_wr_in;
  wire logic step1 = wr & ~io_word_in & (io_addr_in == CFG_ADDR_HI) &
    (io_wdata_in[15:8] == UNLOCK_B1);
  wire logic step2 = wr & ~io_word_in & (io_addr_in == CFG_ADDR) &
    (io_wdata_in[7:0] == UNLOCK_B2);
  wire logic step3 = wr & io_word_in & (io_addr_in == CFG_ADDR) &
    (io_wdata_in == UNLOCK_W3);

  // ****************************************************************
  // Sequence state
  // ****************************************************************
  // Any other access in between restarts the sequence
  always_comb begin
    state_nxt = state_r;
    unlock_nxt = 1'b0;
    if (io_req_in) begin
      unique case (state_r)
        IDLE: state_nxt = step1 ? GOT_FIRST : IDLE;
        GOT_FIRST: state_nxt = step2 ? GOT_SECOND :
          (step1 ? GOT_FIRST : IDLE);
        GOT_SECOND: begin
          unlock_nxt = step3;
          state_nxt = step1 ? GOT_FIRST : IDLE;
        end
        default: state_nxt = IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= IDLE;
      unlock_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      unlock_r <= unlock_nxt;
    end
  end

  assign unlock_out = unlock_r;

endmodule : unlock_seq

/* File: hdl/io_space_remap_decoder.sv */
/*
  I/O space remap decoder: the address configuration register, the
  unlock sequence that opens the expanded space, and the chip-select
  decode for the legacy-compatible peripherals and the expanded slot.
  Assumes the core presents one-cycle I/O requests on mclk_in with a
  byte address; odd-address bytes travel on data bits 15:8.
*/
`timescale 1ns/1ns
module io_space_remap_decoder
  import iomap_pkg::*;
#(
  parameter int ADDR_W = IO_ADDR_W
)
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Core I/O cycle
  input wire logic io_req_in,
  input wire logic io_wr_in,
  input wire logic io_word_in,
  input wire logic [ADDR_W-1:0] io_addr_in,
  input wire logic [15:0] io_wdata_in,
  // Answer to the core
  output logic io_ack_out,
  output logic io_cfg_hit_out,
  output logic [15:0] io_rdata_out,
  // Peripheral selects
  output logic timer_sel_out,
  output logic dma_sel_out,
  output logic master_intc_sel_out,
  output logic slave_intc_sel_out,
  output logic serial0_sel_out,
  output logic serial1_sel_out,
  output logic expanded_other_sel_out,
  output logic external_io_out,
  // Configuration state
  output logic [15:0] address_config_out
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // The window tables are fixed at a 16-bit I/O space
  if (ADDR_W != IO_ADDR_W) begin : g_bad_width
    $error("io_space_remap_decoder: ADDR_W must be 16");
  end

  // The read-back word puts the enable bit on top
  if (ESE_BIT != 15) begin : g_bad_ese
    $error("io_space_remap_decoder: enable bit must be bit 15");
  end

  // Remap mask must cover exactly the six remap bits
  localparam logic [15:0] REMAP_BITS = (16'h0001 << TIMER_REMAP_BIT) |
    (16'h0001 << DMA_REMAP_BIT) |
    (16'h0001 << MINTC_REMAP_BIT) |
    (16'h0001 << SINTC_REMAP_BIT) |
    (16'h0001 << SERIAL0_REMAP_BIT) |
    (16'h0001 << SERIAL1_REMAP_BIT);
  if (REMAP_BITS != REMAP_MASK) begin : g_bad_mask
    $error("io_space_remap_decoder: remap mask mismatch");
  end

  // Tables must keep legacy and expanded slots aligned
  for (genvar c = 0; c < NWIN; c++) begin : g_tbl_chk
    localparam int LOW_W = (c == PER_SERIAL0 || c == PER_SERIAL1) ?
      8 : 10;
    if (EXP_LO[c][LOW_W-1:0] != LEG_LO[c][LOW_W-1:0]) begin : g_bad_lo
      $error("io_space_remap_decoder: window low bits differ");
    end
    if (EXP_HI[c][LOW_W-1:0] != LEG_HI[c][LOW_W-1:0]) begin : g_bad_hi
      $error("io_space_remap_decoder: window high bits differ");
    end
    if (EXP_LO[c][15:12] != EXP_SLOT) begin : g_bad_slot
      $error("io_space_remap_decoder: window outside expanded slot");
    end
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic expanded_space_enable_r;
  logic expanded_space_enable_nxt;
  logic [15:0] remap_r;
  logic [15:0] remap_nxt;
  logic unlock_pulse;
  logic [NWIN-1:0] leg_hit;
  logic [NWIN-1:0] exp_hit;
  logic [NPER-1:0] per_hit;
  logic ack_r;
  logic cfg_hit_r;
  logic [15:0] rdata_r;
  logic [NPER-1:0] sel_r;
  logic exp_other_r;
  logic external_r;
  logic [15:0] cfg_word;

  // ****************************************************************
  // Window match
  // ****************************************************************
  function automatic logic in_window(input logic [15:0] addr,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction : in_window

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  // Interrupts must be masked by software so nothing breaks
  unlock_seq u_unlock (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .io_req_in(io_req_in),
    .io_wr_in(io_wr_in),
    .io_word_in(io_word_in),
    .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in),
    .unlock_out(unlock_pulse)
  );

  // ****************************************************************
  // Configuration register decode
  // ****************************************************************
  wire logic wr = io_req_in & io_wr_in;
  wire logic rd = io_req_in & ~io_wr_in;
  wire logic [9:0] low10 = io_addr_in[9:0];
  wire logic upper_zero = (io_addr_in[15:10] == 6'h00);
  // Only A9:0 matter while the expanded space is closed
  wire logic cfg_sel_leg = (low10[9:1] == CFG_ADDR[9:1]);
  // Full decode once the expanded space is open
  wire logic cfg_sel_full = (io_addr_in[15:1] == CFG_ADDR[15:1]);
  // Reachable at 22H in every mapping state
  wire logic cfg_sel = expanded_space_enable_r ? cfg_sel_full :
    cfg_sel_leg;
  // Lanes are split so a byte to 23H can never touch the remap bits
  wire logic cfg_lo_lane = cfg_sel & (io_word_in | ~io_addr_in[0]);
  wire logic cfg_hi_lane = cfg_sel & (io_word_in | io_addr_in[0]);
  wire logic byte_hi_zero = wr & cfg_hi_lane & ~io_word_in &
    (io_wdata_in[15:8] == UNLOCK_B1);
  // Writes only land while the space is open
  wire logic cfg_wr_lo = wr & cfg_lo_lane & expanded_space_enable_r;
  wire logic cfg_wr_hi = wr & cfg_hi_lane & expanded_space_enable_r;

  // Enable bit: completed unlock wins over any clear
  always_comb begin
    expanded_space_enable_nxt = expanded_space_enable_r;
    if (unlock_pulse) begin
      expanded_space_enable_nxt = 1'b1;
    end else if (byte_hi_zero) begin
      expanded_space_enable_nxt = 1'b0;
    end else if (cfg_wr_hi) begin
      expanded_space_enable_nxt = io_wdata_in[ESE_BIT];
    end
  end

  // Remap bits keep their value when the enable drops
  always_comb begin
    remap_nxt = remap_r;
    if (cfg_wr_lo) begin
      remap_nxt = io_wdata_in & REMAP_MASK;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      expanded_space_enable_r <= CFG_RESET[ESE_BIT];
    end else begin
      expanded_space_enable_r <= expanded_space_enable_nxt;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      remap_r <= CFG_RESET & REMAP_MASK;
    end else begin
      remap_r <= remap_nxt;
    end
  end

  // Enable bit reads back in bit 15
  assign cfg_word = {expanded_space_enable_r, remap_r[14:0]};

  // ****************************************************************
  // Remap bits by peripheral
  // ****************************************************************
  wire logic timer_remap = remap_r[TIMER_REMAP_BIT];
  wire logic dma_remap = remap_r[DMA_REMAP_BIT];
  wire logic master_intc_remap = remap_r[MINTC_REMAP_BIT];
  wire logic slave_intc_remap = remap_r[SINTC_REMAP_BIT];
  wire logic serial0_remap = remap_r[SERIAL0_REMAP_BIT];
  wire logic serial1_remap = remap_r[SERIAL1_REMAP_BIT];
  // The DMA page block follows the DMA bit, so both move together
  wire logic [NWIN-1:0] win_remap = {dma_remap, serial1_remap,
    serial0_remap, slave_intc_remap, master_intc_remap, dma_remap,
    timer_remap};

  // ****************************************************************
  // Peripheral window decode
  // ****************************************************************
  // Window tables are constants; UART slots move with their remap bits like the rest
  // Low 10 bits (8 for the UARTs) agree between spaces
  for (genvar w = 0; w < NWIN; w++) begin : g_win
    // Legacy slot: A9:0 only when closed, A15:10 zero when open
    assign leg_hit[w] = in_window({6'h00, low10}, LEG_LO[w], LEG_HI[w])
      & (~expanded_space_enable_r | upper_zero)
      & ~win_remap[w]
      & ~cfg_sel;
    // Expanded slot answers only while the space is open
    assign exp_hit[w] = expanded_space_enable_r &
      in_window(io_addr_in, EXP_LO[w], EXP_HI[w]);
  end

  // Each remap bit picks its own peripheral
  for (genvar p = 0; p < NPER; p++) begin : g_per
    assign per_hit[p] = |((leg_hit | exp_hit) & PER_WIN[p]);
  end

  // Rest of the expanded slot belongs to on-chip units
  wire logic exp_other = expanded_space_enable_r &
    (io_addr_in[15:12] == EXP_SLOT) & ~|exp_hit;
  // Unclaimed cycles go to the external bus
  wire logic external = ~cfg_sel & ~|per_hit & ~exp_other;
  wire logic [15:0] rdata_nxt = (rd & cfg_sel) ? cfg_word : 16'h0000;

  // ****************************************************************
  // Answer registers
  // ****************************************************************
  // One cycle of latency keeps every output straight from a flop
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_r <= 1'b0;
      cfg_hit_r <= 1'b0;
    end else begin
      ack_r <= io_req_in;
      cfg_hit_r <= io_req_in & cfg_sel;
    end
  end

  // Idle cycles read as zero so no stale word lingers on the bus
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sel_r <= '0;
    end else begin
      sel_r <= io_req_in ? per_hit : '0;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      exp_other_r <= 1'b0;
      external_r <= 1'b0;
    end else begin
      exp_other_r <= io_req_in & exp_other;
      external_r <= io_req_in & external;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign io_ack_out = ack_r;
  assign io_cfg_hit_out = cfg_hit_r;
  assign io_rdata_out = rdata_r;
  assign timer_sel_out = sel_r[PER_TIMER];
  assign dma_sel_out = sel_r[PER_DMA];
  assign master_intc_sel_out = sel_r[PER_MINTC];
  assign slave_intc_sel_out = sel_r[PER_SINTC];
  assign serial0_sel_out = sel_r[PER_SERIAL0];
  assign serial1_sel_out = sel_r[PER_SERIAL1];
  assign expanded_other_sel_out = exp_other_r;
  assign external_io_out = external_r;
  assign address_config_out = cfg_word;

endmodule : io_space_remap_decoder

/* File: dv/io_remap_checker_asserts.sv */
/*
  Checker for the I/O space remap decoder, bound to its top module.
  Assumes one-cycle core requests and answers one cycle later.
*/
`timescale 1ns/1ns
module io_remap_checker
  import iomap_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock, reset and core cycle
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic io_req_in,
  input wire logic io_wr_in,
  input wire logic io_word_in,
  input wire logic [ADDR_W-1:0] io_addr_in,
  input wire logic [15:0] io_wdata_in,
  // Answer and configuration state
  input wire logic io_ack_out,
  input wire logic io_cfg_hit_out,
  input wire logic [15:0] io_rdata_out,
  input wire logic timer_sel_out,
  input wire logic serial1_sel_out,
  input wire logic expanded_other_sel_out,
  input wire logic external_io_out,
  input wire logic [15:0] address_config_out
);
  wire logic expanded_space_enable = address_config_out[ESE_BIT];
  wire logic wr23z = io_req_in && io_wr_in && !io_word_in &&
    io_addr_in == CFG_ADDR_HI && io_wdata_in[15:8] == UNLOCK_B1;
  wire logic w3 = io_req_in && io_wr_in && io_word_in &&
    io_addr_in == CFG_ADDR && io_wdata_in == UNLOCK_W3;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ****************************************************************
  // Properties
  // ****************************************************************
  a_ack_follows: assert property (io_req_in |=> io_ack_out)
    else $error("no ack one cycle after request");
  a_cfg_hit: assert property (
    io_req_in && io_addr_in == CFG_ADDR |=> io_cfg_hit_out)
    else $error("config access not flagged");
  a_read_back: assert property (
    io_req_in && !io_wr_in && io_addr_in == CFG_ADDR
    |=> io_rdata_out == $past(address_config_out))
    else $error("config read data wrong");
  a_reset_zero: assert property (
    $fell(reset_in) |-> address_config_out == CFG_RESET)
    else $error("config not zero after reset");
  a_reserved_zero: assert property (
    (address_config_out & 16'h7F82) == 16'h0000)
    else $error("reserved config bit set");
  a_locked_stable: assert property (
    !expanded_space_enable |=> $stable(address_config_out[6:0]))
    else $error("remap bits changed while locked");
  a_clear_ese: assert property (
    expanded_space_enable && wr23z |=> ##[0:1] !address_config_out[ESE_BIT])
    else $error("enable not cleared");
  a_unlock_only: assert property (
    $rose(expanded_space_enable) |-> $past(w3, 2))
    else $error("enable set without unlock");
  a_legacy_timer: assert property (
    !expanded_space_enable && !address_config_out[0] && io_req_in &&
    io_addr_in[9:5] == 5'h02 |=> timer_sel_out)
    else $error("legacy timer not selected");
  a_remap_gone: assert property (
    !expanded_space_enable && address_config_out[0] && io_req_in &&
    io_addr_in[9:5] == 5'h02 |=> !timer_sel_out && external_io_out)
    else $error("remapped timer still in legacy space");
  a_expanded_s1: assert property (
    expanded_space_enable && io_req_in && io_addr_in[15:3] == 13'h1F1F |=> serial1_sel_out)
    else $error("expanded second serial not selected");
  a_other_slot: assert property (
    expanded_space_enable && io_req_in && io_addr_in[15:8] == 8'hF4 &&
    io_addr_in[7:3] != 5'h1F |=> expanded_other_sel_out)
    else $error("expanded register not decoded");
  a_upper_lines: assert property (
    expanded_space_enable && io_req_in && io_addr_in[15:10] != 6'h00 &&
    io_addr_in[15:12] != EXP_SLOT |=> external_io_out)
    else $error("upper address lines ignored");

  c_unlock: cover property ($rose(expanded_space_enable));
  c_clear: cover property (expanded_space_enable && wr23z);
  c_remapped: cover property (!expanded_space_enable && address_config_out[0] && io_req_in);
endmodule : io_remap_checker

bind io_space_remap_decoder io_remap_checker #(.ADDR_W(ADDR_W)) chk_inst (
  .mclk_in(mclk_in), .reset_in(reset_in), .io_req_in(io_req_in),
  .io_wr_in(io_wr_in), .io_word_in(io_word_in), .io_addr_in(io_addr_in),
  .io_wdata_in(io_wdata_in), .io_ack_out(io_ack_out),
  .io_cfg_hit_out(io_cfg_hit_out), .io_rdata_out(io_rdata_out),
  .timer_sel_out(timer_sel_out), .serial1_sel_out(serial1_sel_out),
  .expanded_other_sel_out(expanded_other_sel_out),
  .external_io_out(external_io_out),
  .address_config_out(address_config_out));

/* File: dv/core_model.sv */
/*
  Core model: issues one-cycle I/O requests and the unlock sequence.
  Assumes the caller waits for the answer before the next request.
*/
`timescale 1ns/1ns
module core_model
  import iomap_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Core I/O cycle
  output logic io_req_out,
  output logic io_wr_out,
  output logic io_word_out,
  output logic [15:0] io_addr_out,
  output logic [15:0] io_wdata_out
);
  initial begin
    io_req_out = 1'b0;
    io_wr_out = 1'b0;
    io_word_out = 1'b0;
    io_addr_out = 16'h0000;
    io_wdata_out = 16'h0000;
  end

  // Released wr, address and data lines flip so a stale value never looks valid
  task automatic io(input logic wr, input logic word,
                    input logic [15:0] addr, input logic [15:0] data);
    @(negedge mclk_in);
    io_req_out = 1'b1;
    io_wr_out = wr;
    io_word_out = word;
    io_addr_out = addr;
    io_wdata_out = data;
    @(negedge mclk_in);
    io_req_out = 1'b0;
    io_wr_out = ~wr;
    io_addr_out = ~addr;
    io_wdata_out = ~data;
  endtask : io

  // Nothing else may slip in between the three writes
  task automatic unlock();
    io(1'b1, 1'b0, CFG_ADDR_HI, {UNLOCK_B1, 8'hA5});
    io(1'b1, 1'b0, CFG_ADDR, {8'h5A, UNLOCK_B2});
    io(1'b1, 1'b1, CFG_ADDR, UNLOCK_W3);
  endtask : unlock
endmodule : core_model

/* File: dv/testbench.sv */
/*
  Self-checking bench for the I/O space remap decoder.
  Assumes answers settle by the falling edge after the request edge.
*/
`timescale 1ns/1ns
module testbench
  import iomap_pkg::*;
;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  wire logic req, wr, word, ack, hit, other, ext;
  wire logic [15:0] addr, wdata, rdata, cfg;
  wire logic [5:0] sel_v;
  int n_fail = 0;
  int num_checks = 0;

  always #5 mclk_in = ~mclk_in;

  core_model core_model_inst (.mclk_in(mclk_in), .io_req_out(req),
    .io_wr_out(wr), .io_word_out(word), .io_addr_out(addr),
    .io_wdata_out(wdata));

  io_space_remap_decoder io_space_remap_decoder_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .io_req_in(req),
    .io_wr_in(wr), .io_word_in(word), .io_addr_in(addr),
    .io_wdata_in(wdata), .io_ack_out(ack), .io_cfg_hit_out(hit),
    .io_rdata_out(rdata), .timer_sel_out(sel_v[0]),
    .dma_sel_out(sel_v[1]), .master_intc_sel_out(sel_v[2]),
    .slave_intc_sel_out(sel_v[3]), .serial0_sel_out(sel_v[4]),
    .serial1_sel_out(sel_v[5]), .expanded_other_sel_out(other),
    .external_io_out(ext), .address_config_out(cfg));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read one address; expected: bit 7 external, 6 other, 5..0 selects
  task automatic dec(input logic [15:0] a, input logic [15:0] exp);
    core_model_inst.io(1'b0, 1'b0, a, 16'h0000);
    chk({7'h00, ack, ext, other, sel_v}, exp | 16'h0100);
  endtask : dec

  task automatic cfg_is(input logic [15:0] exp);
    core_model_inst.io(1'b0, 1'b0, CFG_ADDR, 16'h0000);
    chk(rdata, exp);
    chk({15'h0000, hit}, 16'h0001);
    chk(cfg, exp);
  endtask : cfg_is

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_locked();
    cfg_is(CFG_RESET);
    core_model_inst.io(1'b1, 1'b1, CFG_ADDR, 16'h807D);
    cfg_is(16'h0000);
    core_model_inst.io(1'b1, 1'b0, CFG_ADDR_HI, 16'h00FF);
    core_model_inst.io(1'b0, 1'b0, 16'h0040, 16'h0000);
    core_model_inst.io(1'b1, 1'b0, CFG_ADDR, 16'h0080);
    core_model_inst.io(1'b1, 1'b1, CFG_ADDR, 16'h0080);
    @(negedge mclk_in);
    cfg_is(16'h0000);
  endtask : t_locked

  task automatic t_dos();
    for (int w = 0; w < NPER; w++)
      dec(LEG_HI[w] | 16'h0400, 16'h0001 << w);
    dec(16'h0300, 16'h0080);
    dec(16'h0490, 16'h0002);
    dec(16'hF9C0, 16'h0080);
  endtask : t_dos

  task automatic t_enhanced();
    core_model_inst.unlock();
    @(negedge mclk_in);
    cfg_is(16'h8000);
    for (int w = 0; w < NPER; w++) begin
      dec(LEG_LO[w], 16'h0001 << w);
      dec(EXP_HI[w], 16'h0001 << w);
    end
    dec(16'hF400, 16'h0040);
    dec(16'hF090, 16'h0002);
    dec(16'h0440, 16'h0080);
  endtask : t_enhanced

  task automatic t_remap_bits();
    int n;
    for (int w = 0; w < NPER; w++) begin
      n = (w + 1) % NPER;
      core_model_inst.io(1'b1, 1'b0, CFG_ADDR,
        {8'h00, 8'h01 << WIN_REMAP_BIT[w]});
      dec(LEG_LO[w], 16'h0080);
      dec(EXP_LO[w], 16'h0001 << w);
      dec(LEG_LO[n], 16'h0001 << n);
    end
    core_model_inst.io(1'b1, 1'b1, CFG_ADDR, 16'hFFFF);
    cfg_is(16'h807D);
    for (int w = 0; w < NPER; w++) begin
      dec(LEG_LO[w], 16'h0080);
      dec(EXP_LO[w], 16'h0001 << w);
    end
  endtask : t_remap_bits

  task automatic t_nonintrusive();
    core_model_inst.io(1'b1, 1'b0, CFG_ADDR_HI, 16'h00FF);
    @(negedge mclk_in);
    cfg_is(16'h007D);
    for (int w = 0; w < NPER; w++)
      dec(LEG_LO[w], 16'h0080);
    core_model_inst.io(1'b1, 1'b1, CFG_ADDR, 16'h0000);
    cfg_is(16'h007D);
  endtask : t_nonintrusive

  initial begin
    repeat (12) @(negedge mclk_in);
    reset_in = 1'b0;
    t_locked();
    t_dos();
    t_enhanced();
    t_remap_bits();
    t_nonintrusive();
    close_out();
  end

  // Whole run is under two hundred cycles
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
endmodule : testbench
